// file: flash_ctrl_pkg.sv
// Constants, types and register map shared by the flash protection controller
package flash_ctrl_pkg;

  // Register byte offsets on the Wishbone side
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] ADDR_OFF = 8'h04;
  localparam logic [7:0] DATA_OFF = 8'h08;
  localparam logic [7:0] STATUS_OFF = 8'h0c;
  localparam logic [7:0] RDATA_OFF = 8'h10;
  localparam logic [7:0] COUNT_OFF = 8'h14;

  // Field positions
  localparam int CTRL_START_BIT = 8;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_REFUSED_BIT = 2;
  localparam int ST_NEED_DATA_BIT = 3;
  localparam int ST_PROTECTED_BIT = 4;
  localparam int ST_LOCKED_BIT = 5;
  localparam int ST_MODE_LSB = 8;

  // Host command codes written to CTRL[3:0]
  localparam logic [3:0] CMD_RESET = 4'h0;
  localparam logic [3:0] CMD_ENTER_LOCK = 4'h1;
  localparam logic [3:0] CMD_LOCK_READ = 4'h2;
  localparam logic [3:0] CMD_LOCK_PROG = 4'h3;
  localparam logic [3:0] CMD_ENTER_PWD = 4'h4;
  localparam logic [3:0] CMD_PWD_PROG = 4'h5;
  localparam logic [3:0] CMD_EXIT = 4'h6;
  localparam logic [3:0] CMD_BUF_PROG = 4'h7;
  localparam logic [3:0] CMD_PROT_READ = 4'h8;

  // Flash bus addresses and data codes (byte-wide mode)
  localparam logic [23:0] UNLOCK_ADDR1 = 24'h00_0aaa;
  localparam logic [23:0] UNLOCK_ADDR2 = 24'h00_0555;
  localparam logic [23:0] LOCK_READ_ADDR = 24'h00_0000;
  localparam logic [7:0] UNLOCK_DATA1 = 8'haa;
  localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
  localparam logic [7:0] LOCK_ENTRY_CODE = 8'h40;
  localparam logic [7:0] PWD_ENTRY_CODE = 8'h60;
  localparam logic [7:0] PROGRAM_CODE = 8'ha0;
  localparam logic [7:0] EXIT_CODE1 = 8'h90;
  localparam logic [7:0] EXIT_CODE2 = 8'h00;
  localparam logic [7:0] RESET_CODE = 8'hf0;
  localparam logic [7:0] BUF_LOAD_CODE = 8'h25;
  localparam logic [7:0] BUF_CONFIRM_CODE = 8'h29;
  localparam logic [15:0] LOCKED_WORD = 16'h0001;

  // Write buffer limits: five command cycles plus data words stay within 37
  localparam int BUF_MAX_CYCLES = 37;
  localparam int BUF_OVERHEAD = 5;
  localparam logic [5:0] BUF_MAX_WORDS = 6'(BUF_MAX_CYCLES - BUF_OVERHEAD);

  // Bus cycle timing at 200 MHz; least times round up
  localparam int CLK_PERIOD_NS = 5;
  localparam int T_SETUP_NS = 10;
  localparam int T_PULSE_NS = 35;
  localparam int T_HOLD_NS = 10;
  localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CYC = (T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_LAT = 2;

  typedef enum logic [1:0] {MODE_ARRAY, MODE_LOCKREG, MODE_PASSWORD} mode_type;

  typedef struct packed {
    logic is_read;
    logic last;
    logic wait_data;
    logic [23:0] addr;
    logic [15:0] data;
  } step_type;

endpackage

// file: flash_cycle_engine.sv
// Pin engine: runs one asynchronous write or read cycle on the flash pins
`timescale 1ns/1ps
`default_nettype none
module flash_cycle_engine
  import flash_ctrl_pkg::*;
#(
  parameter int SETUP_CYCLES = SETUP_CYC,
  parameter int PULSE_CYCLES = PULSE_CYC,
  parameter int HOLD_CYCLES = HOLD_CYC
)(
  input wire logic clk_i,
  input wire logic rst_i,
  flash_cycle_if.eng cyc,
  output logic [23:0] flash_addr_o,
  output logic [15:0] flash_dq_o,
  input wire logic [15:0] flash_dq_i,
  output logic flash_dq_oe_n_o,
  output logic flash_ce_n_o,
  output logic flash_we_n_o,
  output logic flash_oe_n_o
);

  initial
  begin
    if (SETUP_CYCLES < 1 || PULSE_CYCLES < 1 || HOLD_CYCLES < 1 ||
        PULSE_CYCLES + SYNC_LAT > 255)
      $error("flash_cycle_engine: cycle counts out of range");
  end

  typedef enum logic [1:0] {ENG_IDLE, ENG_SETUP, ENG_PULSE, ENG_HOLD} eng_state_type;

  eng_state_type state_reg, state_next;
  logic [7:0] cnt_reg, cnt_next;
  logic rd_reg;
  logic [15:0] dq_meta_reg, dq_sync_reg, rdata_reg;
  logic done_reg;
  logic [23:0] addr_reg;
  logic [15:0] dq_out_reg;
  logic oe_n_reg, ce_n_reg, we_n_reg, dq_oe_n_reg;
  logic count_end;

  // A read pulse is stretched by the synchroniser delay so the sample is settled data
  assign count_end = (cnt_reg == 8'd1);

  // Phase sequencing
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg - 8'd1;
    case (state_reg)
      ENG_IDLE:
      begin
        cnt_next = 8'(SETUP_CYCLES);
        if (cyc.req)
          state_next = ENG_SETUP;
      end
      ENG_SETUP:
        if (count_end)
        begin
          state_next = ENG_PULSE;
          cnt_next = rd_reg ? 8'(PULSE_CYCLES + SYNC_LAT) : 8'(PULSE_CYCLES);
        end
      ENG_PULSE:
        if (count_end)
        begin
          state_next = ENG_HOLD;
          cnt_next = 8'(HOLD_CYCLES);
        end
      ENG_HOLD:
        if (count_end)
          state_next = ENG_IDLE;
      default:
        state_next = ENG_IDLE;
    endcase
  end

  // Pin drive; data is driven only for write cycles, high byte zero in commands
  always_ff @(posedge clk_i)
  begin
    dq_meta_reg <= flash_dq_i;
    dq_sync_reg <= dq_meta_reg;
    if (rst_i)
    begin
      state_reg <= ENG_IDLE;
      cnt_reg <= 8'h00;
      rd_reg <= 1'b0;
      addr_reg <= 24'h00_0000;
      dq_out_reg <= 16'h0000;
      dq_oe_n_reg <= 1'b1;
      ce_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      done_reg <= 1'b0;
      rdata_reg <= 16'h0000;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      done_reg <= (state_reg == ENG_HOLD) && count_end;
      if (state_reg == ENG_IDLE && cyc.req)
      begin
        rd_reg <= cyc.is_read;
        addr_reg <= cyc.addr;
        dq_out_reg <= cyc.wdata;
        dq_oe_n_reg <= cyc.is_read;
        ce_n_reg <= 1'b0;
      end
      if (state_next == ENG_PULSE && state_reg == ENG_SETUP)
      begin
        we_n_reg <= rd_reg;
        oe_n_reg <= ~rd_reg;
      end
      if (state_reg == ENG_PULSE && count_end)
      begin
        we_n_reg <= 1'b1;
        oe_n_reg <= 1'b1;
        if (rd_reg)
          rdata_reg <= dq_sync_reg;
      end
      if (state_reg == ENG_HOLD && count_end)
      begin
        ce_n_reg <= 1'b1;
        dq_oe_n_reg <= 1'b1;
      end
    end
  end

  assign cyc.done = done_reg;
  assign cyc.rdata = rdata_reg;
  assign flash_addr_o = addr_reg;
  assign flash_dq_o = dq_out_reg;
  assign flash_dq_oe_n_o = dq_oe_n_reg;
  assign flash_ce_n_o = ce_n_reg;
  assign flash_we_n_o = we_n_reg;
  assign flash_oe_n_o = oe_n_reg;

endmodule
`default_nettype wire

// file: flash_cycle_if.sv
// Single flash bus cycle request and answer between sequencer and pin engine
`timescale 1ns/1ps
`default_nettype none
interface flash_cycle_if;
  logic req;
  logic is_read;
  logic [23:0] addr;
  logic [15:0] wdata;
  logic done;
  logic [15:0] rdata;
  modport seq (output req, output is_read, output addr, output wdata,
               input done, input rdata);
  modport eng (input req, input is_read, input addr, input wdata,
               output done, output rdata);
endinterface
`default_nettype wire

// file: flash_device_model.sv
// Behavioural flash device decoding protection command sequences
`timescale 1ns/1ps
`default_nettype none
module flash_device_model (
  input wire logic ce_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic [23:0] addr_i,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o
);
  logic [1:0] mode_reg;
  logic [2:0] step_reg;
  logic pend_reg, p;
  logic [15:0] lock_reg, held_reg, ans;
  logic [15:0] pwd_reg [4];
  wire [13:0] a = addr_i[13:0];
  wire [7:0] d = dq_i[7:0];
  // Power-up: array read, nothing pending
  initial
  begin
    {mode_reg, step_reg, pend_reg, lock_reg, held_reg} = 0;
  end
  ////////////////////////////////////////
  // Erase, suspend, resume and mode lock bits never come from the host
  // Cycles latch on the rising write strobe; a stray cycle sticks until reset
  always @(posedge we_n_i)
  begin
    p = pend_reg;
    pend_reg = 0;
    if (ce_n_i !== 1'b0) ; // Unknown select at power-up is no cycle
    else if (d == 8'hf0 && !p) {mode_reg, step_reg} = 0;
    else if (p && mode_reg == 1) lock_reg = dq_i;
    else if (p) pwd_reg[addr_i[1:0]] = dq_i;
    else if (step_reg == 0 && a == 14'h0aaa && d == 8'haa) step_reg = 1;
    else if (step_reg == 1 && a == 14'h0555 && d == 8'h55) step_reg = 2;
    else if (step_reg == 2 && a == 14'h0aaa && mode_reg == 0 && (d == 8'h40 || d == 8'h60))
      {mode_reg, step_reg} = {d[5] ? 2'd2 : 2'd1, 3'd0};
    else if (step_reg == 0 && mode_reg != 0 && d == 8'ha0) pend_reg = 1;
    else if (step_reg == 0 && mode_reg != 0 && d == 8'h90) step_reg = 4;
    else if (step_reg == 4 && d == 8'h00) {mode_reg, step_reg} = 0;
    else step_reg = 7;
  end
  // Lock word at offset zero, else protection indicator; odd blocks are protected
  assign ans = (mode_reg == 1 && a == 0) ? lock_reg : {15'h0, ~addr_i[16]};
  // Released bus shows the inverse of the last answer so stale data cannot pass
  always @(posedge oe_n_i) held_reg = ~ans;
  assign dq_o = (!ce_n_i && !oe_n_i) ? ans : held_reg;
endmodule
`default_nettype wire

// file: flash_protect_host.sv
// Host controller that drives flash protection command sequences from Wishbone
// Summary of operation
// - Lock region entry writes AAA/AA, 555/55, AAA/40.
// - Lock bit program: write A0 then the value, addresses don't care.
// - Exit lock region or password set with 90 then 00; back to array read.
// - Password set entry writes AAA/AA, 555/55, AAA/60.
// - Host sends buffer word count as words to load minus one.
// - Sequence cycles are writes except listed read and verify cycles.
// - Wrong or misordered cycles leave device undefined; host must send reset.
// - Reset command returns to array read after lock operations or failures.
// - Buffer program only from array read; at most 37 cycles.
// - Mode instructions only after the matching entry sequence.
// - Host must exit a protection set or the device hangs.
//
// Implementation choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module flash_protect_host
  import flash_ctrl_pkg::*;
#(
  parameter int ADDR_W = 24
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [23:0] flash_addr_o,
  output logic [15:0] flash_dq_o,
  input wire logic [15:0] flash_dq_i,
  output logic flash_dq_oe_n_o,
  output logic flash_ce_n_o,
  output logic flash_we_n_o,
  output logic flash_oe_n_o
);

  initial
  begin
    if (ADDR_W != 24)
      $error("flash_protect_host: only a 24-bit flash address is supported");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Byte-lane merge for Wishbone writes
  function automatic logic [31:0] merge_sel(input logic [31:0] old_val,
                                            input logic [31:0] new_val,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
        res[i*8 +: 8] = new_val[i*8 +: 8];
    end
    return res;
  endfunction

  // Command cycle with data byte only; upper data bits stay zero, address passed as given
  function automatic step_type wr_step(input logic [23:0] addr, input logic [7:0] code,
                                       input logic last);
    step_type s;
    s.is_read = 1'b0;
    s.last = last;
    s.wait_data = 1'b0;
    s.addr = addr;
    s.data = {8'h00, code};
    return s;
  endfunction

  // Mode gate for every host command
  function automatic logic cmd_allowed(input logic [3:0] cmd, input mode_type mode,
                                       input logic [5:0] words);
    logic ok;
    case (cmd)
      CMD_RESET: ok = 1'b1;
      CMD_ENTER_LOCK, CMD_ENTER_PWD: ok = (mode == MODE_ARRAY);
      CMD_LOCK_READ, CMD_LOCK_PROG: ok = (mode == MODE_LOCKREG);
      CMD_PWD_PROG: ok = (mode == MODE_PASSWORD);
      CMD_EXIT, CMD_PROT_READ: ok = (mode != MODE_ARRAY);
      CMD_BUF_PROG: ok = (mode == MODE_ARRAY) && (words != 6'd0) &&
                         (words <= BUF_MAX_WORDS);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Bus cycle number idx of command cmd
  function automatic step_type step_fn(input logic [3:0] cmd, input logic [5:0] idx,
                                       input logic [23:0] addr, input logic [15:0] data,
                                       input logic [5:0] words);
    step_type s;
    logic [23:0] blk;
    blk = {addr[23:16], 16'h0000};
    s = wr_step(UNLOCK_ADDR1, RESET_CODE, 1'b1);
    case (cmd)
      CMD_ENTER_LOCK, CMD_ENTER_PWD:
        case (idx)
          6'd0: s = wr_step(UNLOCK_ADDR1, UNLOCK_DATA1, 1'b0);
          6'd1: s = wr_step(UNLOCK_ADDR2, UNLOCK_DATA2, 1'b0);
          default: s = wr_step(UNLOCK_ADDR1, (cmd == CMD_ENTER_LOCK) ?
                               LOCK_ENTRY_CODE : PWD_ENTRY_CODE, 1'b1);
        endcase
      CMD_LOCK_READ, CMD_PROT_READ:
      begin
        s.is_read = 1'b1;
        s.addr = (cmd == CMD_LOCK_READ) ? LOCK_READ_ADDR : blk;
        s.data = 16'h0000;
      end
      CMD_LOCK_PROG, CMD_PWD_PROG:
        if (idx == 6'd0)
          s = wr_step(24'h00_0000, PROGRAM_CODE, 1'b0);
        else
        begin
          s = wr_step(24'h00_0000, data[7:0], 1'b1);
          if (cmd == CMD_PWD_PROG)
          begin
            s.addr = {22'h00_0000, addr[1:0]};
            s.data = data;
          end
        end
      CMD_EXIT:
        s = (idx == 6'd0) ? wr_step(24'h00_0000, EXIT_CODE1, 1'b0) :
                            wr_step(24'h00_0000, EXIT_CODE2, 1'b1);
      CMD_BUF_PROG:
        if (idx == 6'd0)
          s = wr_step(UNLOCK_ADDR1, UNLOCK_DATA1, 1'b0);
        else if (idx == 6'd1)
          s = wr_step(UNLOCK_ADDR2, UNLOCK_DATA2, 1'b0);
        else if (idx == 6'd2)
          s = wr_step(blk, BUF_LOAD_CODE, 1'b0);
        else if (idx == 6'd3)
        begin
          s = wr_step(blk, 8'h00, 1'b0);
          s.data = 16'(words - 6'd1);
        end
        else if (idx < 6'd4 + words)
        begin
          s = wr_step(addr + 24'(idx - 6'd4), 8'h00, 1'b0);
          s.data = data;
          s.wait_data = 1'b1;
        end
        else
          s = wr_step(blk, BUF_CONFIRM_CODE, 1'b1);
      default:
        s = wr_step(UNLOCK_ADDR1, RESET_CODE, 1'b1);
    endcase
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: ack one cycle after the strobe, dropped the cycle after

  logic wb_ack_reg;
  logic [31:0] wb_dat_reg, rd_word;
  logic wb_req, wr_ctrl, wr_addr, wr_data, wr_status, wr_count;
  logic [31:0] ctrl_merged, addr_merged, data_merged, count_merged, status_merged;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_reg;
  assign wr_ctrl = wb_req && wb_we_i && (wb_adr_i == CTRL_OFF);
  assign wr_addr = wb_req && wb_we_i && (wb_adr_i == ADDR_OFF);
  assign wr_data = wb_req && wb_we_i && (wb_adr_i == DATA_OFF);
  assign wr_status = wb_req && wb_we_i && (wb_adr_i == STATUS_OFF);
  assign wr_count = wb_req && wb_we_i && (wb_adr_i == COUNT_OFF);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and sequencer state

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_ISSUE, SEQ_WAIT} seq_state_type;

  seq_state_type state_reg, state_next;
  mode_type mode_reg, mode_next;
  logic [3:0] cmd_reg;
  logic [23:0] addr_reg;
  logic [15:0] data_reg, rdata_reg;
  logic [5:0] count_reg, idx_reg, idx_next;
  logic data_valid_reg, done_reg, refused_reg, protected_reg, locked_reg;
  logic req_reg, req_next;
  step_type step;
  logic start_req, start_ok, issue_go, take_data, finish, clr_done, clr_refused;

  flash_cycle_if fc ();

  assign ctrl_merged = merge_sel({20'h0_0000, 3'b000, 1'b0, 4'h0, cmd_reg}, wb_dat_i, wb_sel_i);
  assign addr_merged = merge_sel({8'h00, addr_reg}, wb_dat_i, wb_sel_i);
  assign data_merged = merge_sel({16'h0000, data_reg}, wb_dat_i, wb_sel_i);
  assign count_merged = merge_sel({26'h000_0000, count_reg}, wb_dat_i, wb_sel_i);
  assign status_merged = merge_sel(32'h0000_0000, wb_dat_i, wb_sel_i);

  // Start decode; a start while busy or in the wrong mode is refused, not queued
  assign start_req = wr_ctrl && ctrl_merged[CTRL_START_BIT];
  assign start_ok = start_req && (state_reg == SEQ_IDLE) &&
                    cmd_allowed(ctrl_merged[3:0], mode_reg, count_reg);
  assign clr_done = wr_status && status_merged[ST_DONE_BIT];
  assign clr_refused = wr_status && status_merged[ST_REFUSED_BIT];

  // Current bus cycle; buffer data words wait until software supplies them
  assign step = step_fn(cmd_reg, idx_reg, addr_reg, data_reg, count_reg);
  assign issue_go = (state_reg == SEQ_ISSUE) && (!step.wait_data || data_valid_reg);
  assign take_data = issue_go && step.wait_data;
  assign finish = (state_reg == SEQ_WAIT) && fc.done && step.last;

  assign fc.req = req_reg;
  assign fc.is_read = step.is_read;
  assign fc.addr = step.addr;
  assign fc.wdata = step.data;

  // Sequencer walk over the command's cycles, strictly in order
  always_comb
  begin
    state_next = state_reg;
    idx_next = idx_reg;
    req_next = 1'b0;
    case (state_reg)
      SEQ_IDLE:
        if (start_ok)
        begin
          state_next = SEQ_ISSUE;
          idx_next = 6'd0;
        end
      SEQ_ISSUE:
        if (issue_go)
        begin
          req_next = 1'b1;
          state_next = SEQ_WAIT;
        end
      SEQ_WAIT:
        if (fc.done)
        begin
          state_next = step.last ? SEQ_IDLE : SEQ_ISSUE;
          idx_next = idx_reg + 6'd1;
        end
      default:
        state_next = SEQ_IDLE;
    endcase
  end

  // Mode tracking: only reset and exit return the device to array read
  always_comb
  begin
    mode_next = mode_reg;
    if (finish)
      case (cmd_reg)
        CMD_RESET, CMD_EXIT: mode_next = MODE_ARRAY;
        CMD_ENTER_LOCK: mode_next = MODE_LOCKREG;
        CMD_ENTER_PWD: mode_next = MODE_PASSWORD;
        default: mode_next = mode_reg;
      endcase
  end

  // Sequencer, mode and request flip-flops
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= SEQ_IDLE;
      mode_reg <= MODE_ARRAY;
      idx_reg <= 6'd0;
      req_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      idx_reg <= idx_next;
      req_reg <= req_next;
    end
  end

  // Software-visible registers; hardware set of a flag wins over its clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cmd_reg <= CMD_RESET;
      addr_reg <= 24'h00_0000;
      data_reg <= 16'h0000;
      count_reg <= 6'd1;
      data_valid_reg <= 1'b0;
      done_reg <= 1'b0;
      refused_reg <= 1'b0;
    end
    else
    begin
      if (start_ok)
        cmd_reg <= ctrl_merged[3:0];
      if (wr_addr && state_reg == SEQ_IDLE)
        addr_reg <= addr_merged[23:0];
      if (wr_data)
        data_reg <= data_merged[15:0];
      if (wr_count && state_reg == SEQ_IDLE)
        count_reg <= count_merged[5:0];
      data_valid_reg <= wr_data || (data_valid_reg && !take_data);
      done_reg <= finish || (done_reg && !clr_done);
      refused_reg <= (start_req && !start_ok) || (refused_reg && !clr_refused);
    end
  end

  // Read results: low data bit low means protected, word 0001 means locked
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdata_reg <= 16'h0000;
      protected_reg <= 1'b0;
      locked_reg <= 1'b0;
    end
    else if (finish && step.is_read)
    begin
      rdata_reg <= fc.rdata;
      protected_reg <= ~fc.rdata[0];
      locked_reg <= (fc.rdata == LOCKED_WORD);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux and bus answer; unmapped reads give zero and still ack

  assign rd_word = (wb_adr_i == CTRL_OFF) ? {28'h000_0000, cmd_reg} :
                   (wb_adr_i == ADDR_OFF) ? {8'h00, addr_reg} :
                   (wb_adr_i == DATA_OFF) ? {16'h0000, data_reg} :
                   (wb_adr_i == STATUS_OFF) ? {22'h00_0000, mode_reg, 2'b00,
                                               locked_reg, protected_reg,
                                               (state_reg == SEQ_ISSUE) && step.wait_data &&
                                               !data_valid_reg,
                                               refused_reg, done_reg,
                                               state_reg != SEQ_IDLE} :
                   (wb_adr_i == RDATA_OFF) ? {16'h0000, rdata_reg} :
                   (wb_adr_i == COUNT_OFF) ? {26'h000_0000, count_reg} : 32'h0000_0000;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_reg <= 1'b0;
      wb_dat_reg <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_reg <= wb_req;
      if (wb_req)
        wb_dat_reg <= rd_word;
    end
  end

  assign wb_ack_o = wb_ack_reg;
  assign wb_dat_o = wb_dat_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Pin engine

  flash_cycle_engine #(
    .SETUP_CYCLES(SETUP_CYC),
    .PULSE_CYCLES(PULSE_CYC),
    .HOLD_CYCLES(HOLD_CYC)
  ) u_engine (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc(fc.eng),
    .flash_addr_o(flash_addr_o),
    .flash_dq_o(flash_dq_o),
    .flash_dq_i(flash_dq_i),
    .flash_dq_oe_n_o(flash_dq_oe_n_o),
    .flash_ce_n_o(flash_ce_n_o),
    .flash_we_n_o(flash_we_n_o),
    .flash_oe_n_o(flash_oe_n_o)
  );

endmodule
`default_nettype wire

// file: flash_protect_host_checker.sv
// Pin and bus answer assertions for the flash protection host
`timescale 1ns/1ps
`default_nettype none
module flash_protect_host_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [23:0] flash_addr_o,
  input wire logic flash_dq_oe_n_o,
  input wire logic flash_ce_n_o,
  input wire logic flash_we_n_o,
  input wire logic flash_oe_n_o
);
  // One domain, so clock and reset are given once
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  // Strobes stay apart so a command cycle is never taken as a read
  AST_NO_RW: assert property (flash_we_n_o || flash_oe_n_o)
    else $error("write and read strobes low together");
  AST_WE_IN_CE: assert property (!flash_we_n_o |-> !flash_ce_n_o)
    else $error("write strobe outside chip select");
  AST_WR_DRIVE: assert property (!flash_we_n_o |-> !flash_dq_oe_n_o)
    else $error("data not driven in write strobe");
  AST_RD_FLOAT: assert property (!flash_oe_n_o |-> flash_dq_oe_n_o)
    else $error("host drives data during read");
  AST_ADDR_HOLD: assert property (
    !flash_ce_n_o && !$past(flash_ce_n_o) |-> $stable(flash_addr_o))
    else $error("address moved inside a cycle");
  AST_WE_PULSE: assert property (
    $fell(flash_we_n_o) |-> !flash_we_n_o [*7] ##1 flash_we_n_o)
    else $error("write pulse length wrong");
  AST_CE_GAP: assert property ($rose(flash_ce_n_o) |-> flash_ce_n_o [*2])
    else $error("cycles closer than two idle clocks");
  AST_ACK_NEXT: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not a single next cycle");
endmodule
bind flash_protect_host flash_protect_host_checker i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .flash_addr_o, .flash_dq_oe_n_o, .flash_ce_n_o, .flash_we_n_o, .flash_oe_n_o);
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the flash protection host and device model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import flash_ctrl_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, ce_n, we_n, oe_n, dq_oe_n;
  logic [7:0] adr = 0, b;
  logic [31:0] dat = 0, dat_o, st, q;
  logic [23:0] fa;
  logic [15:0] hq, dq, bus, w;
  int err_count = 0, n_compared = 0, cyc_cnt = 0, i, k;
  assign bus = dq_oe_n ? dq : hq;
  flash_protect_host i_flash_protect_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hf),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .flash_addr_o(fa), .flash_dq_o(hq), .flash_dq_i(bus),
    .flash_dq_oe_n_o(dq_oe_n), .flash_ce_n_o(ce_n), .flash_we_n_o(we_n), .flash_oe_n_o(oe_n));
  flash_device_model i_flash_device_model (.ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n),
    .addr_i(fa), .dq_i(bus), .dq_o(dq));
  ////////////////////////////////////////
  // 200 MHz clock and a hang limit well above the expected run
  initial forever #2.5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000)
    begin
      err_count++;
      give_verdict;
    end
  end
  task automatic give_verdict;
    if (err_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Classic single cycle: hold until ack is sampled, then idle one cycle
  task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    {cyc, stb, we, adr, dat} <= {2'b11, wr, a, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = dat_o;
    {cyc, stb} <= 2'b00;
    @(posedge clk_i);
  endtask
  // Start a command, poll for an outcome, clear the sticky flags, keep them in st
  task automatic run(input logic [3:0] c, input logic [23:0] a, input logic [15:0] d);
    wb(1, ADDR_OFF, {8'h00, a});
    wb(1, DATA_OFF, {16'h0000, d});
    wb(1, CTRL_OFF, {23'h0, 1'b1, 4'h0, c});
    for (i = 0; i < 300; i++)
    begin
      wb(0, STATUS_OFF, 0);
      if (q[ST_DONE_BIT] === 1'b1 || q[ST_REFUSED_BIT] === 1'b1) break;
    end
    st = q;
    chk("command outcome", 1, st[ST_DONE_BIT] | st[ST_REFUSED_BIT]);
    wb(1, STATUS_OFF, 32'h0000_0006);
    wb(0, STATUS_OFF, 0);
    st = q | (st & 32'h0000_0006);
  endtask
  ////////////////////////////////////////
  initial
  begin
    void'($urandom(18936));
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    wb(0, 8'h40, 0);
    chk("unmapped read", 0, q);
    run(CMD_LOCK_READ, 0, 0);
    chk("refused lock read", 1, st[ST_REFUSED_BIT]);
    run(CMD_ENTER_LOCK, 24'($urandom), 0);
    chk("device lock mode", 1, i_flash_device_model.mode_reg);
    for (k = 0; k < 2; k++)
    begin
      w = k ? 16'h0001 : 16'($urandom);
      run(CMD_LOCK_PROG, 24'($urandom), w);
      run(CMD_LOCK_READ, 0, 0);
      wb(0, RDATA_OFF, 0);
      chk("lock word", {24'h0, w[7:0]}, q);
      chk("locked flag", w[7:0] == 8'h01, st[ST_LOCKED_BIT]);
    end
    run(CMD_ENTER_LOCK, 0, 0);
    chk("refused reentry", 1, st[ST_REFUSED_BIT]);
    run(CMD_EXIT, 0, 0);
    chk("device after exit", 0, i_flash_device_model.mode_reg);
    run(CMD_ENTER_PWD, 0, 0);
    chk("password mode", 2, st[9:8]);
    for (k = 0; k < 4; k++)
    begin
      w = 16'($urandom);
      run(CMD_PWD_PROG, 24'(k), w);
      chk("password word", w, i_flash_device_model.pwd_reg[k]);
    end
    for (k = 0; k < 4; k++)
    begin
      b = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
      run(CMD_PROT_READ, {b, 16'($urandom)}, 0);
      chk("protected flag", b[0], st[ST_PROTECTED_BIT]);
    end
    run(CMD_BUF_PROG, 0, 0);
    chk("refused buffer", 1, st[ST_REFUSED_BIT]);
    run(CMD_RESET, 0, 0);
    chk("device after reset", 0, i_flash_device_model.mode_reg);
    // One-word buffer program from array read; its data word is the one run writes to DATA before the start
    wb(1, COUNT_OFF, 1);
    run(CMD_BUF_PROG, 24'($urandom), 16'($urandom));
    chk("buffer done", 1, st[ST_DONE_BIT]);
    chk("buffer not refused", 0, st[ST_REFUSED_BIT]);
    give_verdict;
  end
endmodule
`default_nettype wire
